// file: inc/io_space_pkg.sv
package io_space_pkg;

  // ****************************************
  // Address map of the I/O space
  // ****************************************
  localparam int         NUM_SLOTS      = 27;
  localparam int         SLOT_W         = 5;
  localparam logic [7:0] IO_BIT_LAST    = 8'h1f;
  localparam logic [7:0] IO_PORT_LAST   = 8'h3f;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] EXT_IO_FIRST   = 8'h60;
  localparam logic [7:0] EXT_IO_LAST    = 8'hff;
  localparam logic [7:0] RESET_VALUE    = 8'h00;

  // Data-space address of each slot
  localparam logic [7:0] SLOT_ADDR [NUM_SLOTS] = '{
    8'h3c, 8'h3e,                                           // event flags, scratch 0
    8'h4a, 8'h4b, 8'h4c, 8'h4d, 8'h4e, 8'h50, 8'h53, 8'h54, 8'h55, 8'h57,
    8'h5d, 8'h5e, 8'h5f, 8'h60, 8'h61, 8'h64, 8'h66, 8'h68, 8'h69, 8'h6b,
    8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'h70};

  // Bits software reads and writes
  localparam logic [7:0] RW_MASK [NUM_SLOTS] = '{
    8'h00, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h01, 8'hff, 8'hcf, 8'h0f, 8'h0f, 8'h73, 8'h9f,
    8'hff, 8'h07, 8'hff, 8'h7f, 8'h8f, 8'hef, 8'hff, 8'h07, 8'h0f, 8'hff,
    8'h7f, 8'hff, 8'h07, 8'h27, 8'h07};

  // Status flags cleared by writing a one
  localparam logic [7:0] W1C_MASK [NUM_SLOTS] = '{
    8'h03, 8'h00,
    8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Bits that show peripheral state and ignore writes
  localparam logic [7:0] RO_MASK [NUM_SLOTS] = '{
    8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h40,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ****************************************
  // Access styles and carriers
  // ****************************************
  typedef enum logic [3:0] {
    OP_NONE,
    OP_PORT_READ,
    OP_PORT_WRITE,
    OP_SET_IO_BIT,
    OP_CLEAR_IO_BIT,
    OP_SKIP_IF_IO_BIT_SET,
    OP_SKIP_IF_IO_BIT_CLEAR,
    OP_MEMORY_READ,
    OP_MEMORY_WRITE
  } access_op_t;

  typedef struct packed {
    access_op_t  op;
    logic [7:0]  addr;
    logic [2:0]  bitSel;
    logic [7:0]  wdata;
  } core_req_t;

  typedef struct packed {
    logic        valid;
    logic        refused;
    logic        skip;
    logic [7:0]  rdata;
  } core_resp_t;

endpackage : io_space_pkg

// file: rtl/io_space_decoder.sv
`timescale 1ns/1ps

module io_space_decoder
  import io_space_pkg::*;
#(
  parameter int SLOTS = NUM_SLOTS
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic                        clockEnable,
  // Core access port
  input  wire core_req_t                   req,
  output core_resp_t                       resp,
  // Peripheral side
  input  wire logic [SLOTS-1:0][7:0]       eventSet,
  input  wire logic [SLOTS-1:0][7:0]       hwStatus,
  output logic      [SLOTS-1:0][7:0]       regOut
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (SLOTS != NUM_SLOTS) begin : g_bad_slots
    $error("io_space_decoder: SLOTS must equal the size of the address map");
  end

  // One spare index code marks an address with no register behind it
  if (SLOT_W < $clog2(NUM_SLOTS + 1)) begin : g_bad_width
    $error("io_space_decoder: slot index too narrow for the address map");
  end

  // ****************************************
  // Decoding helpers
  // ****************************************
  localparam logic [SLOT_W-1:0] NO_SLOT = '1;

  function automatic logic [SLOT_W-1:0] slotOf(input logic [7:0] a);
    logic [SLOT_W-1:0] s;
    s = NO_SLOT;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (SLOT_ADDR[i] == a) begin
        s = SLOT_W'(i);
      end
    end
    return s;
  endfunction : slotOf

  // Also called for numbers above 0x3f; from 0xe0 the sum wraps in eight bits, but styleOk refuses those
  function automatic logic [7:0] ioToData(input logic [7:0] ioNum);
    return ioNum + IO_DATA_OFFSET;
  endfunction : ioToData

  function automatic logic inBitRange(input logic [7:0] ioNum);
    return (ioNum <= IO_BIT_LAST);
  endfunction : inBitRange

  function automatic logic inPortRange(input logic [7:0] ioNum);
    return (ioNum <= IO_PORT_LAST);
  endfunction : inPortRange

  // Below 0x20 lies the working register file, not this block
  function automatic logic inDataRange(input logic [7:0] addr);
    return (addr >= IO_DATA_OFFSET);
  endfunction : inDataRange

  // Bits that hold state in this block
  function automatic logic [7:0] storedBits(input int i);
    return RW_MASK[i] | W1C_MASK[i];
  endfunction : storedBits

  function automatic logic [7:0] readView(input logic [7:0] stored,
                                          input logic [7:0] status,
                                          input int         i);
    // Reserved bits are in no mask and so read as zero
    return (stored & storedBits(i)) | (status & RO_MASK[i]);
  endfunction : readView

  function automatic logic masksOverlap();
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      hit = hit | ((RW_MASK[i] & W1C_MASK[i]) != 8'h00);
      hit = hit | ((RW_MASK[i] & RO_MASK[i]) != 8'h00);
      hit = hit | ((W1C_MASK[i] & RO_MASK[i]) != 8'h00);
    end
    return hit;
  endfunction : masksOverlap

  // A bit in RW_MASK and W1C_MASK would be both written and cleared in one cycle; no bit may sit in two masks
  if (masksOverlap()) begin : g_bad_masks
    $error("io_space_decoder: access masks overlap");
  end

  // ****************************************
  // Access decode
  // ****************************************
  logic [7:0]        regFile      [NUM_SLOTS];
  logic [7:0]        next_regFile [NUM_SLOTS];
  core_resp_t        next_resp;
  logic [7:0]        dataAddr;
  logic              styleOk;
  logic              isWrite;
  logic              isBitTest;
  logic [7:0]        writeMask;
  logic [7:0]        writeValue;
  logic [SLOT_W-1:0] slot;
  logic [7:0]        readValue;
  logic [7:0]        bitOne;

  always_comb begin
    bitOne     = 8'h01 << req.bitSel;
    dataAddr   = req.addr;
    styleOk    = 1'b0;
    isWrite    = 1'b0;
    isBitTest  = 1'b0;
    writeMask  = 8'h00;
    writeValue = 8'h00;
    case (req.op)
      OP_PORT_READ: begin
        styleOk  = inPortRange(req.addr);
        dataAddr = ioToData(req.addr);
      end
      OP_PORT_WRITE: begin
        // Numbers stop at 0x3f, so the extended area is never reached here
        styleOk    = inPortRange(req.addr);
        dataAddr   = ioToData(req.addr);
        isWrite    = 1'b1;
        writeMask  = 8'hff;
        writeValue = req.wdata;
      end
      OP_SET_IO_BIT: begin
        styleOk    = inBitRange(req.addr);
        dataAddr   = ioToData(req.addr);
        isWrite    = 1'b1;
        writeMask  = bitOne;
        writeValue = bitOne;
      end
      OP_CLEAR_IO_BIT: begin
        styleOk    = inBitRange(req.addr);
        dataAddr   = ioToData(req.addr);
        isWrite    = 1'b1;
        writeMask  = bitOne;
        writeValue = 8'h00;
      end
      OP_SKIP_IF_IO_BIT_SET, OP_SKIP_IF_IO_BIT_CLEAR: begin
        styleOk   = inBitRange(req.addr);
        dataAddr  = ioToData(req.addr);
        isBitTest = 1'b1;
      end
      OP_MEMORY_READ: begin
        styleOk = inDataRange(req.addr);
      end
      OP_MEMORY_WRITE: begin
        styleOk    = inDataRange(req.addr);
        isWrite    = 1'b1;
        writeMask  = 8'hff;
        writeValue = req.wdata;
      end
      default: begin
        styleOk = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Read path and answer
  // ****************************************
  always_comb begin
    slot      = slotOf(dataAddr);
    readValue = 8'h00;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (slot == SLOT_W'(i)) begin
        readValue = readView(regFile[i], hwStatus[i], i);
      end
    end
  end

  always_comb begin
    next_resp         = '0;
    next_resp.valid   = (req.op != OP_NONE);
    next_resp.refused = (req.op != OP_NONE) && !styleOk;
    if (styleOk && !isWrite) begin
      next_resp.rdata = readValue;
    end
    if (styleOk && isBitTest) begin
      // Skip when the tested bit equals the level asked for
      next_resp.skip = (readValue[req.bitSel] == (req.op == OP_SKIP_IF_IO_BIT_SET));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      resp <= '0;
    end else if (clockEnable) begin
      resp <= next_resp;
    end
  end

  // ****************************************
  // Register updates
  // ****************************************
  always_comb begin
    logic [7:0] v;
    logic [7:0] m;
    v = 8'h00;
    m = 8'h00;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      v = regFile[i];
      m = (styleOk && isWrite && slot == SLOT_W'(i)) ? writeMask : 8'h00;
      // Plain bits take the written value under the mask only
      v = (v & ~(m & RW_MASK[i])) | (writeValue & m & RW_MASK[i]);
      // Flags clear on a written one; a written zero leaves them
      v = v & ~(m & writeValue & W1C_MASK[i]);
      // A peripheral event in the same cycle beats the clear
      v = v | (eventSet[i] & storedBits(i));
      next_regFile[i] = v;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regFile[i] <= RESET_VALUE;
      end
    end else if (clockEnable) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        regFile[i] <= next_regFile[i];
      end
    end
  end

  // ****************************************
  // Register contents to the peripherals
  // ****************************************
  always_comb begin
    for (int i = 0; i < NUM_SLOTS; i++) begin
      regOut[i] = regFile[i] & storedBits(i);
    end
  end

endmodule : io_space_decoder

// file: bench/io_space_asserts.sv
`timescale 1ns/1ps
module io_space_asserts
  import io_space_pkg::*;
#(parameter int SLOTS = NUM_SLOTS) (
  input wire logic                  clock,
  input wire logic                  resetn,
  input wire logic                  clockEnable,
  input wire core_req_t             req,
  input wire core_resp_t            resp,
  input wire logic [SLOTS-1:0][7:0] eventSet,
  input wire logic [SLOTS-1:0][7:0] hwStatus,
  input wire logic [SLOTS-1:0][7:0] regOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic take = clockEnable && req.op != OP_NONE;
  sequence refusedAns; resp.valid && resp.refused && resp.rdata == 8'h00; endsequence
  sequence okAns; resp.valid && !resp.refused; endsequence
  bit_range_a: assert property (
    take && req.op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SKIP_IF_IO_BIT_SET,
                           OP_SKIP_IF_IO_BIT_CLEAR} && req.addr > IO_BIT_LAST
    |=> refusedAns) else $error("bit op out of range");
  skip_value_a: assert property (
    take && req.op == OP_SKIP_IF_IO_BIT_SET && req.addr == 8'h1c
    |=> okAns ##0 resp.skip == |($past(regOut[0]) & (8'h01 << $past(req.bitSel))))
    else $error("skip");
  set_only_a: assert property (
    take && req.op == OP_SET_IO_BIT && req.addr == 8'h1e
    |=> regOut[1] == ($past(regOut[1]) | (8'h01 << $past(req.bitSel)))) else $error("bit set");
  flag_clear_a: assert property (
    take && req.op == OP_PORT_WRITE && req.addr == 8'h1c && !eventSet[0]
    |=> regOut[0] == ($past(regOut[0]) & ~$past(req.wdata))) else $error("flag clear");
  port_range_a: assert property (
    take && req.op inside {OP_PORT_READ, OP_PORT_WRITE} && req.addr > IO_PORT_LAST
    |=> refusedAns) else $error("port range");
  offset_map_a: assert property (
    take && req.op == OP_PORT_WRITE && req.addr == 8'h2a
    |=> okAns ##0 regOut[2] == $past(req.wdata)) else $error("offset map");
  ext_write_a: assert property (
    take && req.op == OP_MEMORY_WRITE && req.addr == 8'h61
    |=> okAns ##0 regOut[16] == ($past(req.wdata) & 8'h8f)) else $error("extended write");
  reserved_read_a: assert property (
    take && req.op == OP_MEMORY_READ && req.addr == 8'h5c
    |=> okAns ##0 resp.rdata == 8'h00) else $error("reserved read");
endmodule : io_space_asserts

bind io_space_decoder io_space_asserts #(.SLOTS(SLOTS)) chk (.clock(clock), .resetn(resetn),
  .clockEnable(clockEnable), .req(req), .resp(resp), .eventSet(eventSet),
  .hwStatus(hwStatus), .regOut(regOut));

// file: bench/core_model.sv
`timescale 1ns/1ps
module core_model
  import io_space_pkg::*;
(
  // Core clock
  input  wire logic       clock,
  // Access port
  input  wire core_resp_t resp,
  output core_req_t       req
);
  initial req = '0;
  // Callers also write out-of-range targets, which are refused; mapped writes carry zero in reserved bits
  task automatic access(input access_op_t op, input logic [7:0] addr, input logic [2:0] bitSel,
                        input logic [7:0] wdata, output core_resp_t r);
    @(posedge clock);
    #1 req = '{op, addr, bitSel, wdata};
    @(posedge clock);
    #1 r = resp;
    req.op = OP_NONE;
  endtask : access
endmodule : core_model

// file: bench/test_io_space_decoder.sv
`timescale 1ns/1ps
module test_io_space_decoder;
  import io_space_pkg::*;
  logic                      clock;
  logic                      resetn;
  core_req_t                 req;
  core_resp_t                resp;
  core_resp_t                r;
  logic [NUM_SLOTS-1:0][7:0] eventSet;
  logic [NUM_SLOTS-1:0][7:0] regOut;
  logic [NUM_SLOTS-1:0][7:0] hwStatus;
  int                        errorCnt = 0;
  int                        compares = 0;
  io_space_decoder #(.SLOTS(NUM_SLOTS)) dut (.clock(clock), .resetn(resetn), .clockEnable(1'b1),
    .req(req), .resp(resp), .eventSet(eventSet), .hwStatus(hwStatus), .regOut(regOut));
  core_model core (.clock(clock), .resp(resp), .req(req));
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  task check(input string name, input logic [9:0] seen, input logic [9:0] exp);
    compares++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task summarize();
    $display("compares %0d errors %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Response packed as refused, skip, read data
  task ex(input access_op_t op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
          input logic [9:0] exp);
    core.access(op, a, b, d, r);
    check("valid", {9'h000, r.valid}, 10'h001);
    check(op.name(), {r.refused, r.skip, r.rdata}, exp);
  endtask : ex
  initial begin
    #25000;
    errorCnt++;
    summarize();
  end
  initial begin
    resetn = 0;
    eventSet = '0;
    hwStatus = '0;
    repeat (4) @(posedge clock);
    #1 resetn = 1;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      ex(OP_MEMORY_READ, SLOT_ADDR[i], 0, 0, {2'b0, RESET_VALUE});
    end
    // Live status on every line must still leave reserved bits and holes at zero
    hwStatus = '1;
    ex(OP_MEMORY_READ, 8'h57, 0, 0, 10'h040);
    ex(OP_MEMORY_READ, 8'h5c, 0, 0, 10'h000);
    hwStatus = '0;
    ex(OP_PORT_WRITE, 8'h2a, 0, 8'h55, 10'h000);
    ex(OP_PORT_READ, 8'h2a, 0, 0, 10'h055);
    ex(OP_MEMORY_READ, 8'h4a, 0, 0, 10'h055);
    ex(OP_PORT_WRITE, 8'h40, 0, 8'h11, 10'h200);
    ex(OP_PORT_READ, 8'h41, 0, 0, 10'h200);
    ex(OP_MEMORY_WRITE, 8'h61, 0, 8'h8f, 10'h000);
    ex(OP_MEMORY_READ, 8'h61, 0, 0, {2'b0, RW_MASK[16]});
    ex(OP_MEMORY_WRITE, 8'h10, 0, 8'h01, 10'h200);
    ex(OP_SET_IO_BIT, 8'h1e, 3, 0, 10'h000);
    ex(OP_SET_IO_BIT, 8'h1e, 0, 0, 10'h000);
    ex(OP_SET_IO_BIT, 8'h20, 1, 0, 10'h200);
    ex(OP_CLEAR_IO_BIT, 8'h1e, 3, 0, 10'h000);
    ex(OP_PORT_READ, 8'h1e, 0, 0, 10'h001);
    @(posedge clock);
    #1 eventSet[0] = 8'h03;
    @(posedge clock);
    #1 eventSet[0] = 8'h00;
    ex(OP_SKIP_IF_IO_BIT_SET, 8'h1c, 1, 0, 10'h103);
    ex(OP_SKIP_IF_IO_BIT_CLEAR, 8'h1c, 1, 0, 10'h003);
    ex(OP_SKIP_IF_IO_BIT_CLEAR, 8'h3c, 1, 0, 10'h200);
    ex(OP_SET_IO_BIT, 8'h1c, 0, 0, 10'h000);
    ex(OP_CLEAR_IO_BIT, 8'h1c, 1, 0, 10'h000);
    ex(OP_PORT_READ, 8'h1c, 0, 0, 10'h002);
    ex(OP_PORT_WRITE, 8'h1c, 0, 8'h00, 10'h000);
    ex(OP_MEMORY_READ, 8'h3c, 0, 0, 10'h002);
    ex(OP_MEMORY_WRITE, 8'h3c, 0, 8'h02, 10'h000);
    check("flags", {2'b0, regOut[0]}, 10'h000);
    // A flag event in the cycle of its clear must survive
    fork
      ex(OP_MEMORY_WRITE, 8'h3c, 0, 8'h02, 10'h000);
      begin
        @(posedge clock);
        #1 eventSet[0] = 8'h02;
        @(posedge clock);
        #1 eventSet[0] = 8'h00;
      end
    join
    check("set wins", {2'b0, regOut[0]}, 10'h002);
    ex(OP_PORT_WRITE, 8'h1c, 0, 8'h02, 10'h000);
    check("flags", {2'b0, regOut[0]}, 10'h000);
    summarize();
  end
endmodule : test_io_space_decoder
